// ===== hdl/ccsu_pkg.sv
// Constants and types shared by the common command status unit
package ccsu_pkg;
	// Standard event bit positions
	localparam int EV_PON = 7;
	localparam int EV_CME = 5;
	localparam int EV_EXE = 4;
	localparam int EV_DDE = 3;
	localparam int EV_QYE = 2;
	localparam int EV_OPC = 0;
	// Bits that exist in the event and enable layout (6 and 1 read zero)
	localparam logic [7:0] EV_MASK = 8'hbd;
	// Status byte bit positions
	localparam int SB_OPER = 7;
	localparam int SB_MSS  = 6;
	localparam int SB_ESB  = 5;
	localparam int SB_MAV  = 4;
	localparam int SB_QUES = 3;
	// Reset values
	localparam logic [7:0] ENABLE_RST = 8'h00;
	localparam logic [7:0] LATCH_RST  = 8'h00;
	// Reply characters: completion one, decimal digit zero, identity comma
	localparam logic [7:0] CHAR_ONE   = 8'h31;
	localparam logic [7:0] CHAR_ZERO  = 8'h30;
	localparam logic [7:0] CHAR_COMMA = 8'h2c;
	// Identity reply ROM depth and address width
	localparam int IDN_LEN  = 32;
	localparam int IDN_AW   = 5;
	// Command codes delivered by the upstream parser
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0,
		CMD_CLS  = 4'h1,
		CMD_ESE  = 4'h2,
		CMD_ESEQ = 4'h3,
		CMD_ESRQ = 4'h4,
		CMD_IDNQ = 4'h5,
		CMD_OPC  = 4'h6,
		CMD_OPCQ = 4'h7,
		CMD_OTHER = 4'h8
	} ccsu_cmd_t;
	// Reply sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_NUM  = 3'b001,
		ST_IDN  = 3'b010,
		ST_WAIT = 3'b011,
		ST_DONE = 3'b100
	} ccsu_state_t;
endpackage

// ===== hdl/ccsu_idn_rom.sv
// Identity reply ROM with registered read data
`timescale 1ns/1ps
module ccsu_idn_rom (
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	input  wire logic [ccsu_pkg::IDN_AW-1:0] addr,
	output logic      [7:0]                  data
);
	// Maker field is arbitrary: "MAKER,1234A,0,f1.00"; unused slots pad zero
	function automatic logic [7:0] rom_at(input logic [ccsu_pkg::IDN_AW-1:0] a);
		logic [8*19-1:0] s;
		s = "MAKER,1234A,0,f1.00";
		if (a < 5'h13) begin
			rom_at = s[8*(18-a) +: 8];
		end else begin
			rom_at = 8'h00;
		end
	endfunction

	// Registered read so the reply path sees a flop
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			data <= 8'h00;
		end else begin
			data <= rom_at(addr);
		end
	end
endmodule // ccsu_idn_rom

// ===== hdl/ccsu_top.sv
// Common command status unit: status clearing, event registers, identity, completion
// Function
// - Clear clears event registers and status byte
// - Clear empties the error queue
// - Clear cancels pending completion request, not query
// - Clear after terminator flushes output, clears MAV
// - Summary bit is OR of enabled events
// - Shared eight-bit event layout, bits 6,1 zero
// - Enable write takes 0..255; reset loads zero
// - Enable write saved when power-on clear zero
// - Event query returns latch and clears it
// - Identity reply fields in fixed order
// - Completion bit set only after operations finish
// - Finished means executed, settled, nothing armed
// - Completion request does not stall parsing
// - Completion query queues ASCII one
// - Completion query stalls later commands
// - Accepts mandatory and optional common commands
// - Parser accepts long and short keywords
// - Question-mark commands exist only as queries
// - Status byte bit layout fixed
// - Power-up restores or clears enables per setting
`timescale 1ns/1ps
module ccsu_top (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] cmd_code,
	input  wire logic       cmd_valid,
	input  wire logic       cmd_after_term,
	input  wire logic [7:0] cmd_value,
	input  wire logic       ops_executed,
	input  wire logic       level_settled,
	input  wire logic       trig_armed,
	input  wire logic       err_cme,
	input  wire logic       err_exe,
	input  wire logic       err_dde,
	input  wire logic       err_qye,
	input  wire logic       oper_summary,
	input  wire logic       ques_summary,
	input  wire logic [7:0] sre_value,
	input  wire logic       psc_setting,
	input  wire logic [7:0] nv_enable,
	input  wire logic       out_ready,
	output logic            cmd_ready,
	output logic [7:0]      out_data,
	output logic            out_valid,
	output logic            out_flush,
	output logic            errq_clear,
	output logic            sub_event_clear,
	output logic            nv_write,
	output logic [7:0]      nv_data,
	output logic [7:0]      enable_out,
	output logic [7:0]      status_byte,
	output logic            mav
);
	// All state of the unit in one record
	typedef struct packed {
		logic                        por;         // Power-up work still to do
		logic [7:0]                  enable_reg;  // Standard event enable
		logic [7:0]                  latch_reg;   // Standard event latch
		logic                        opc_pend;    // Completion request armed
		ccsu_pkg::ccsu_state_t       state;       // Reply sequencer
		logic [7:0]                  num_reg;     // Value being printed
		logic [1:0]                  digit;       // Decimal digit index
		logic                        lead;        // Leading digit already sent
		logic [ccsu_pkg::IDN_AW-1:0] idn_addr;    // Identity ROM address
		logic                        idn_prime;   // ROM read latency slot
		logic [7:0]                  out_data;
		logic                        out_valid;
		logic                        mav;
		logic                        out_flush;
		logic                        errq_clear;
		logic                        sub_clear;
		logic                        nv_write;
		logic [7:0]                  nv_data;
		logic [7:0]                  status_byte;
		logic                        cmd_ready;
	} ccsu_st_t;

	ccsu_st_t  st_reg;           // Registered state
	ccsu_st_t  st_next;          // Next state
	logic [7:0] rom_data;        // Identity character
	logic       ops_done;        // Pending operations finished
	logic [7:0] err_set;         // Error events this cycle
	logic       esb;             // Event summary
	logic       take;            // Command taken this cycle
	logic [7:0] dig_val;         // Current decimal digit
	// Identity characters come from a small registered ROM
	ccsu_idn_rom u_rom (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.addr     (st_reg.idn_addr),
		.data     (rom_data)
	);
	// Decimal digit of the value being printed
	always_comb begin
		case (st_reg.digit)
			2'd2:    dig_val = st_reg.num_reg / 8'd100;
			2'd1:    dig_val = (st_reg.num_reg / 8'd10) % 8'd10;
			default: dig_val = st_reg.num_reg % 8'd10;
		endcase
	end

	// Next state logic for the whole unit
	always_comb begin
		st_next = st_reg;
		ops_done = ops_executed && level_settled && !trig_armed;
		err_set = '0;
		err_set[ccsu_pkg::EV_CME] = err_cme;
		err_set[ccsu_pkg::EV_EXE] = err_exe;
		err_set[ccsu_pkg::EV_DDE] = err_dde;
		err_set[ccsu_pkg::EV_QYE] = err_qye;
		// commands stall while a reply is in flight
		take = cmd_valid && st_reg.cmd_ready;
		st_next.out_flush  = 1'b0;
		st_next.errq_clear = 1'b0;
		st_next.sub_clear  = 1'b0;
		st_next.nv_write   = 1'b0;
		// Output handshake completes a character
		if (st_reg.out_valid && out_ready) begin
			st_next.out_valid = 1'b0;
		end
		// Power-up: enable restored or cleared, power-on event set
		if (st_reg.por) begin
			st_next.por = 1'b0;
			st_next.cmd_ready = 1'b1; // Commands welcome once power-up is done
			// restore only when power-on clear is zero
			st_next.enable_reg = psc_setting ? ccsu_pkg::ENABLE_RST
				: (nv_enable & ccsu_pkg::EV_MASK);
			st_next.latch_reg[ccsu_pkg::EV_PON] = 1'b1;
		end
		// long and short spellings share one code
		if (take) begin
			// query-only commands have only query codes
			case (ccsu_pkg::ccsu_cmd_t'(cmd_code))
				ccsu_pkg::CMD_CLS: begin
					st_next.latch_reg = '0;
					st_next.sub_clear = 1'b1;
					st_next.errq_clear = 1'b1;
					st_next.opc_pend = 1'b0;
					// flush output only after a terminator
					if (cmd_after_term) begin
						st_next.out_flush = 1'b1;
						st_next.out_valid = 1'b0; // MAV follows below
					end
				end
				ccsu_pkg::CMD_ESE: begin
					st_next.enable_reg = cmd_value & ccsu_pkg::EV_MASK;
					// save when power-on clear is zero
					if (!psc_setting) begin
						st_next.nv_write = 1'b1;
						st_next.nv_data  = cmd_value & ccsu_pkg::EV_MASK;
					end
				end
				ccsu_pkg::CMD_ESEQ: begin
					st_next.num_reg   = st_reg.enable_reg;
					st_next.digit     = 2'd2;
					st_next.lead      = 1'b0;
					st_next.state     = ccsu_pkg::ST_NUM;
					st_next.cmd_ready = 1'b0;
				end
				ccsu_pkg::CMD_ESRQ: begin
					st_next.num_reg   = st_reg.latch_reg;
					st_next.latch_reg = '0;
					st_next.digit     = 2'd2;
					st_next.lead      = 1'b0;
					st_next.state     = ccsu_pkg::ST_NUM;
					st_next.cmd_ready = 1'b0;
				end
				ccsu_pkg::CMD_IDNQ: begin
					st_next.idn_addr  = '0;
					st_next.idn_prime = 1'b1;
					st_next.state     = ccsu_pkg::ST_IDN;
					st_next.cmd_ready = 1'b0;
				end
				ccsu_pkg::CMD_OPC: begin
					st_next.opc_pend = 1'b1;
				end
				ccsu_pkg::CMD_OPCQ: begin
					st_next.state     = ccsu_pkg::ST_WAIT;
					st_next.cmd_ready = 1'b0;
				end
				default: begin
				end
			endcase
		end
		// completion bit only once operations finish
		if (st_reg.opc_pend && ops_done) begin
			st_next.opc_pend = 1'b0;
			st_next.latch_reg[ccsu_pkg::EV_OPC] = 1'b1;
		end
		// Hardware events win over a same-cycle clear
		st_next.latch_reg = st_next.latch_reg | err_set;
		// Reply sequencer
		case (st_reg.state)
			ccsu_pkg::ST_IDLE: begin // Keep whatever the dispatch chose
			end
			ccsu_pkg::ST_NUM: begin
				if (!st_reg.out_valid || out_ready) begin
					if (st_reg.digit == 2'd0 || st_reg.lead || dig_val != 8'h00) begin
						st_next.out_data  = ccsu_pkg::CHAR_ZERO + dig_val;
						st_next.out_valid = 1'b1;
						st_next.lead      = 1'b1;
					end
					if (st_reg.digit == 2'd0) begin
						st_next.state = ccsu_pkg::ST_DONE;
					end else begin
						st_next.digit = st_reg.digit - 2'd1;
					end
				end
			end
			ccsu_pkg::ST_IDN: begin
				if (st_reg.idn_prime) begin
					st_next.idn_prime = 1'b0;
				end else if (!st_reg.out_valid || out_ready) begin
					if (rom_data == 8'h00) begin
						st_next.state = ccsu_pkg::ST_DONE;
					end else begin
						st_next.out_data  = rom_data;
						st_next.out_valid = 1'b1;
						st_next.idn_addr  = st_reg.idn_addr + 5'd1;
						st_next.idn_prime = 1'b1;
					end
				end
			end
			ccsu_pkg::ST_WAIT: begin
				if (ops_done && (!st_reg.out_valid || out_ready)) begin
					st_next.out_data  = ccsu_pkg::CHAR_ONE;
					st_next.out_valid = 1'b1;
					st_next.state     = ccsu_pkg::ST_DONE;
				end
			end
			ccsu_pkg::ST_DONE: begin
				// Last character queued; accept commands again
				st_next.state     = ccsu_pkg::ST_IDLE;
				st_next.cmd_ready = 1'b1;
			end
			default: begin
				st_next.state = ccsu_pkg::ST_IDLE;
			end
		endcase
		// MAV tracks the held character; drops once drained or flushed
		st_next.mav = st_next.out_valid;
		esb = |(st_next.latch_reg & st_next.enable_reg & ccsu_pkg::EV_MASK);
		st_next.status_byte = '0;
		st_next.status_byte[ccsu_pkg::SB_OPER] = oper_summary;
		st_next.status_byte[ccsu_pkg::SB_ESB]  = esb;
		st_next.status_byte[ccsu_pkg::SB_MAV]  = st_next.mav;
		st_next.status_byte[ccsu_pkg::SB_QUES] = ques_summary;
		st_next.status_byte[ccsu_pkg::SB_MSS]  = |(st_next.status_byte & sre_value & 8'hbf);
		// bits 6 and 1 read zero
		st_next.latch_reg = st_next.latch_reg & ccsu_pkg::EV_MASK;
	end

	// State register; power-up work flagged at reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg           <= '0;
			st_reg.por       <= 1'b1;
			st_reg.enable_reg <= ccsu_pkg::ENABLE_RST;
			st_reg.latch_reg <= ccsu_pkg::LATCH_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state flops
	assign cmd_ready       = st_reg.cmd_ready;
	assign out_data        = st_reg.out_data;
	assign out_valid       = st_reg.out_valid;
	assign out_flush       = st_reg.out_flush;
	assign errq_clear      = st_reg.errq_clear;
	assign sub_event_clear = st_reg.sub_clear;
	assign nv_write        = st_reg.nv_write;
	assign nv_data         = st_reg.nv_data;
	assign enable_out      = st_reg.enable_reg;
	assign status_byte     = st_reg.status_byte;
	assign mav             = st_reg.mav;

	// latch reads zero after an event query
	chk_esr_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
		(take && cmd_code == 4'h4 && !(|err_set) && !(st_reg.opc_pend && ops_done))
		|=> (st_reg.latch_reg == 8'h00)) else $error("latch not cleared by read");
	chk_cls_errq: assert property (@(posedge core_clk) disable iff (!rst_n)
		(take && cmd_code == 4'h1) |=> errq_clear) else $error("error queue not cleared");
	chk_cls_flush: assert property (@(posedge core_clk) disable iff (!rst_n)
		out_flush |-> $past(take && cmd_code == 4'h1 && cmd_after_term))
		else $error("flush without terminator clear");
	chk_esb_sum: assert property (@(posedge core_clk) disable iff (!rst_n)
		!st_reg.por && !$past(st_reg.por) |->
		status_byte[5] == |(st_reg.latch_reg & st_reg.enable_reg)) else $error("summary wrong");
	chk_ev_layout: assert property (@(posedge core_clk) disable iff (!rst_n)
		((st_reg.latch_reg & 8'h42) == 8'h00) && ((enable_out & 8'h42) == 8'h00))
		else $error("reserved event bits set");
	// nonvolatile save follows an enable write
	chk_nv_save: assert property (@(posedge core_clk) disable iff (!rst_n)
		(take && cmd_code == 4'h2 && !psc_setting) |=> (nv_write && nv_data == enable_out))
		else $error("enable not saved");
	// completion bit not set before finish
	chk_opc_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_reg.opc_pend && !ops_done && !st_reg.latch_reg[0] && !take) |=>
		!st_reg.latch_reg[0]) else $error("completion bit early");
	// no command taken while waiting on completion query
	chk_opcq_stall: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_reg.state == ccsu_pkg::ST_WAIT) |-> !cmd_ready) else $error("accepted during query");
	chk_opcq_char: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_reg.state == ccsu_pkg::ST_WAIT && ops_done && !out_valid) |=>
		(out_valid && out_data == 8'h31)) else $error("wrong completion reply");
	// Main scenarios
	cov_opcq: cover property (@(posedge core_clk) disable iff (!rst_n)
		st_reg.state == ccsu_pkg::ST_WAIT ##[1:20] out_data == 8'h31);
	cov_idn: cover property (@(posedge core_clk) disable iff (!rst_n)
		st_reg.state == ccsu_pkg::ST_IDN ##[1:100] st_reg.state == ccsu_pkg::ST_DONE);
	cov_cls: cover property (@(posedge core_clk) disable iff (!rst_n) out_flush);
endmodule // ccsu_top

// ===== verification/ccsu_ctrl_model.sv
// Bus controller model that drains the unit's output queue
`timescale 1ns/1ps
module ccsu_ctrl_model (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] out_data,
	input  wire logic       out_valid,
	input  wire logic       out_flush,
	input  wire logic       slow,
	output logic            out_ready
);
	// Characters read back so far
	logic [7:0] rx_q[$];
	// Stall phase, flips every cycle
	logic       phase;

	// Ready starts high so nothing blocks at power-up
	initial begin
		out_ready = 1'b1;
		phase     = 1'b0;
	end

	// Ready moves only after the falling edge, never near sampling
	always @(negedge core_clk) begin
		phase     <= ~phase;
		out_ready <= ~slow | phase;
	end

	always @(posedge core_clk) begin
		if (out_flush === 1'b1) begin
			// Flushed queue loses unread characters
			rx_q.delete();
		end else if (rst_n && out_valid === 1'b1 && out_ready) begin
			rx_q.push_back(out_data);
		end
	end
endmodule // ccsu_ctrl_model

// ===== verification/test_common_command_status_unit.sv
// Self-checking bench for the common command status unit
`timescale 1ns/1ps
module test_common_command_status_unit;
	logic        core_clk, rst_n, cmd_valid, cmd_after_term;
	logic [3:0]  cmd_code;
	logic [7:0]  cmd_value, sre_value, nv_enable, out_data, nv_data, enable_out, status_byte;
	logic        ops_executed, level_settled, trig_armed, err_cme, err_exe, err_dde, err_qye;
	logic        oper_summary, ques_summary, psc_setting, out_ready, slow;
	logic        cmd_ready, out_valid, out_flush, errq_clear, sub_event_clear, nv_write, mav;
	// Reference model state
	int          m_latch, m_en;
	// Result counters and pulse counters
	int          mismatches = 0, n_tests = 0;
	int          n_nv = 0, n_errq = 0, n_sub = 0, n_flush = 0, k, e, f, s;
	logic [31:0] rnd;
	// Blocking condition sets: not executed, not settled, still armed
	logic [2:0]  blk [3] = '{3'b010, 3'b100, 3'b111};

	ccsu_top ccsu_top_i (.core_clk(core_clk), .rst_n(rst_n), .cmd_code(cmd_code),
		.cmd_valid(cmd_valid), .cmd_after_term(cmd_after_term), .cmd_value(cmd_value),
		.ops_executed(ops_executed), .level_settled(level_settled), .trig_armed(trig_armed),
		.err_cme(err_cme), .err_exe(err_exe), .err_dde(err_dde), .err_qye(err_qye),
		.oper_summary(oper_summary), .ques_summary(ques_summary), .sre_value(sre_value),
		.psc_setting(psc_setting), .nv_enable(nv_enable), .out_ready(out_ready),
		.cmd_ready(cmd_ready), .out_data(out_data), .out_valid(out_valid),
		.out_flush(out_flush), .errq_clear(errq_clear), .sub_event_clear(sub_event_clear),
		.nv_write(nv_write), .nv_data(nv_data), .enable_out(enable_out),
		.status_byte(status_byte), .mav(mav));

	ccsu_ctrl_model ccsu_ctrl_model_i (.core_clk(core_clk), .rst_n(rst_n),
		.out_data(out_data), .out_valid(out_valid), .out_flush(out_flush),
		.slow(slow), .out_ready(out_ready));

	// Free-running 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Run needs a few hundred cycles; 20000 cycles means a hang
	initial begin
		#200000;
		mismatches++;
		stop_test();
	end

	// Count one-cycle pulses as they appear
	always @(posedge core_clk) begin
		n_nv    += (nv_write === 1'b1);
		n_errq  += (errq_clear === 1'b1);
		n_sub   += (sub_event_clear === 1'b1);
		n_flush += (out_flush === 1'b1);
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// Last eight characters of a string, packed
	function automatic logic [63:0] pack_str(input string v);
		logic [63:0] r;
		r = '0;
		foreach (v[j]) r = {r[55:0], v[j]};
		return r;
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Offer one command, hold it until the unit takes it
	task automatic send(input logic [3:0] c, input logic [7:0] v, input logic t);
		int n;
		n = 0;
		@(negedge core_clk);
		{cmd_code, cmd_value, cmd_after_term, cmd_valid} = {c, v, t, 1'b1};
		while (cmd_ready !== 1'b1 && n < 500) begin
			@(negedge core_clk);
			n++;
		end
		// A command never taken counts against the run
		if (n >= 500) begin
			mismatches++;
		end
		@(negedge core_clk);
		{cmd_code, cmd_valid} = '0;
	endtask

	// Wait for the reply to finish; empty expectation skips the compare
	task automatic collect(input string exp);
		logic [63:0] got;
		int          n;
		n = 0;
		while (!(cmd_ready === 1'b1 && out_valid === 1'b0) && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 400) begin
			mismatches++;
		end
		got = '0;
		foreach (ccsu_ctrl_model_i.rx_q[j]) got = {got[55:0], ccsu_ctrl_model_i.rx_q[j]};
		if (exp.len() > 0) check(got, pack_str(exp));
	endtask

	task automatic query(input logic [3:0] c, input string exp);
		ccsu_ctrl_model_i.rx_q.delete();
		send(c, 8'h00, 1'b0);
		collect(exp);
	endtask

	// Reset and reload the model as power-up does
	task automatic do_reset(input logic psc);
		psc_setting = psc;
		rst_n = 1'b0;
		ticks(8);
		rst_n = 1'b1;
		m_latch = 8'h80;
		m_en = psc ? 0 : nv_enable;
		ticks(2);
	endtask

	task automatic done_test(input string name);
		$display("test %s done", name);
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{rst_n, cmd_code, cmd_valid, cmd_after_term, cmd_value} = '0;
		{ops_executed, level_settled, trig_armed, err_cme, err_exe, err_dde, err_qye} = '0;
		{oper_summary, ques_summary, psc_setting, slow} = '0;
		rnd = 32'h0001563d;
		sre_value = rnd[15:8];
		nv_enable = rnd[7:0] & ccsu_pkg::EV_MASK;
		do_reset(1'b0);
		check(enable_out, m_en);
		query(ccsu_pkg::CMD_ESRQ, "128");
		query(ccsu_pkg::CMD_ESRQ, "0");
		m_latch = 0;
		done_test("power_up");
		// Enable writes: both extremes, then random, storage on and off
		for (int i = 0; i < 5; i++) begin
			rnd = lfsr_next(rnd);
			psc_setting = i[0];
			k = n_nv;
			send(ccsu_pkg::CMD_ESE, (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd[7:0], 1'b0);
			m_en = ((i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd[7:0]) & ccsu_pkg::EV_MASK;
			ticks(2);
			check(enable_out, m_en);
			check(n_nv - k, psc_setting ? 0 : 1);
			if (!psc_setting) begin
				check(nv_data, m_en);
			end
			query(ccsu_pkg::CMD_ESEQ, $sformatf("%0d", m_en));
		end
		done_test("enable");
		// Error events and status byte summaries
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr_next(rnd);
			sre_value = rnd[15:8];
			{err_cme, err_exe, err_dde, err_qye} = rnd[3:0];
			{oper_summary, ques_summary} = rnd[5:4];
			m_latch |= rnd[3:0] << 2;
			ticks(1);
			{err_cme, err_exe, err_dde, err_qye} = 4'h0;
			ticks(2);
			check(status_byte[5], (m_latch & m_en) != 0);
			check({status_byte[7], status_byte[3]}, rnd[5:4]);
			// Master summary: enabled status bits, bit 6 excluded
			s = {rnd[5], 1'b0, (m_latch & m_en) != 0, 1'b0, rnd[4], 3'b000};
			check(status_byte[6], |(s & sre_value));
		end
		query(ccsu_pkg::CMD_ESRQ, $sformatf("%0d", m_latch));
		m_latch = 0;
		done_test("events");
		// Clear right after a terminator
		{err_cme, err_exe} = 2'b11;
		ticks(1);
		{err_cme, err_exe} = 2'b00;
		{e, f, s} = {n_errq, n_flush, n_sub};
		send(ccsu_pkg::CMD_CLS, 8'h00, 1'b1);
		ticks(2);
		check(n_errq - e, 1);
		check(n_flush - f, 1);
		check(n_sub - s, 1);
		check(enable_out, m_en);
		query(ccsu_pkg::CMD_ESRQ, "0");
		done_test("clear");
		// Completion request held back by each condition in turn
		send(ccsu_pkg::CMD_ESE, 8'h01, 1'b0);
		m_en = 1;
		{ops_executed, level_settled, trig_armed} = blk[0];
		send(ccsu_pkg::CMD_OPC, 8'h00, 1'b0);
		query(ccsu_pkg::CMD_ESEQ, "1");
		for (int i = 0; i < 3; i++) begin
			{ops_executed, level_settled, trig_armed} = blk[i];
			ticks(3);
			check(status_byte[5], 1'b0);
		end
		{ops_executed, level_settled, trig_armed} = 3'b110;
		ticks(3);
		check(status_byte[5], 1'b1);
		query(ccsu_pkg::CMD_ESRQ, "1");
		// Clear mid-wait cancels the request; no terminator, no flush
		{ops_executed, level_settled, trig_armed} = blk[1];
		f = n_flush;
		send(ccsu_pkg::CMD_OPC, 8'h00, 1'b0);
		send(ccsu_pkg::CMD_CLS, 8'h00, 1'b0);
		{ops_executed, level_settled, trig_armed} = 3'b110;
		ticks(3);
		check(status_byte[5], 1'b0);
		check(n_flush - f, 0);
		done_test("completion");
		// Completion query stalls the command stream
		{ops_executed, level_settled, trig_armed} = blk[2];
		ccsu_ctrl_model_i.rx_q.delete();
		send(ccsu_pkg::CMD_OPCQ, 8'h00, 1'b0);
		ticks(6);
		check(cmd_ready, 1'b0);
		check(ccsu_ctrl_model_i.rx_q.size(), 0);
		{ops_executed, level_settled, trig_armed} = 3'b110;
		// Reply held: message available must show
		wait (out_valid === 1'b1);
		@(negedge core_clk);
		check({mav, status_byte[4]}, 2'b11);
		collect("1");
		done_test("completion_query");
		// Identity reply through a stalling reader
		slow = 1'b1;
		query(ccsu_pkg::CMD_IDNQ, "");
		k = 0;
		foreach (ccsu_ctrl_model_i.rx_q[j]) k += (ccsu_ctrl_model_i.rx_q[j] == ccsu_pkg::CHAR_COMMA);
		check(k, 3);
		slow = 1'b0;
		done_test("identity");
		// Power-up with clearing selected ignores the stored value
		nv_enable = 8'hbd;
		do_reset(1'b1);
		check(enable_out, m_en);
		done_test("power_clear");
		stop_test();
	end
endmodule // test_common_command_status_unit
